// >>> hw/sea_defines.svh
// Purpose: shared constants for the serial eeprom direct-access link
// Assumes: both ends include this header by its bare name
// Notes: counts are in aclk cycles at 50 MHz
//
// How it works
// - host serial clock at most 4 MHz
// - enable pin high routes spi to eeprom
// - one write procedure for every zone
// - write latch opcode precedes each write
// - status write 00 clears protection bits
// - status: bit7 pin enable, 3:2 protect, 1:0 flags
// - busy flag high during internal write
// - protect bits 11 locked, 00 unlocked
// - host confirms unlock by status read
// - page write: opcode, 16-bit address, data
// - host selects chip, shifts 24-bit header
// - sixteen edges per byte, deselect after last
// - at most 64 bytes per write command
// - bursts stay inside 128-byte aligned region
// - host polls busy flag until it clears
// - latch, page write, poll for each page
// - relock: latch then status write 0C
// - host confirms lock by status read
// - host drops enable pin when finished
// - host pulses device reset afterwards
`ifndef SEA_DEFINES_SVH
`define SEA_DEFINES_SVH
`define SEA_OP_WRITE_LATCH_SET_CMD 8'h06
`define SEA_OP_WRSR 8'h01
`define SEA_OP_WRITE 8'h02
`define SEA_OP_READ 8'h03
`define SEA_OP_RDSR 8'h05
`define SEA_ST_UNLOCK 8'h00
`define SEA_ST_LOCK 8'h0C
`define SEA_BIT_PIN_EN 7
`define SEA_BIT_PROT_HI 3
`define SEA_BIT_PROT_LO 2
`define SEA_BIT_LATCH 1
`define SEA_BIT_BUSY 0
`define SEA_STATUS_RST 8'h00
`define SEA_PAGE_MAX 64
`define SEA_REGION 128
`define SEA_MEM_WORDS 65536
`define SEA_SCK_MAX_KHZ 4000
`define SEA_CLK_KHZ 50000
// half period rounded up so the clock never exceeds the limit
`define SEA_SCK_HALF ((`SEA_CLK_KHZ + 2 * `SEA_SCK_MAX_KHZ - 1) / (2 * `SEA_SCK_MAX_KHZ))
`define SEA_WRITE_BUSY_CYC 2000
`define SEA_RESET_PULSE_CYC 16
// host register byte addresses
`define SEA_A_CTRL 8'h00
`define SEA_A_ADDR 8'h04
`define SEA_A_DATA 8'h08
`define SEA_A_STAT 8'h0C
`endif

// >>> hw/sea_pkg.sv
// Purpose: types used by the host end only
// Assumes: nothing
// Notes: none
`default_nettype none
package sea_pkg;
    typedef enum logic [2:0] {
        SEA_JOB_IDLE, SEA_JOB_UNLOCK, SEA_JOB_PAGE, SEA_JOB_LOCK, SEA_JOB_STATUS, SEA_JOB_FINISH
    } sea_job_t;
endpackage
`default_nettype wire

// >>> hw/sea_link_if.sv
// Purpose: spi direct-access link between host and device
// Assumes: serial output of device is push-pull
// Notes: none
`default_nettype none
interface sea_link_if;
    logic direct_access_enable;
    logic chip_select_n;
    logic sck;
    logic serial_in_pin;
    logic serial_out_pin;
    logic device_reset_n;
    modport host (output direct_access_enable, output chip_select_n, output sck, output serial_in_pin,
                  output device_reset_n, input serial_out_pin);
    modport device (input direct_access_enable, input chip_select_n, input sck, input serial_in_pin,
                    input device_reset_n, output serial_out_pin);
endinterface
`default_nettype wire

// >>> hw/sea_shifter.sv
// Purpose: one spi byte shifter for the host end
// Assumes: start only while idle
// Notes: mode 0, msb first
`include "sea_defines.svh"
`default_nettype none
module sea_shifter (
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    // request
    input wire logic start,
    input wire logic [7:0] tx_byte,
    output logic done,
    output logic [7:0] rx_byte,
    // pins
    output logic sck,
    output logic mosi,
    input wire logic miso_sync
);
    logic [5:0] div_reg;
    logic [3:0] edge_reg;
    logic busy_reg;
    logic [7:0] sh_reg;
    wire tick = busy_reg && (div_reg == 6'(`SEA_SCK_HALF - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_reg <= 6'h0;
            edge_reg <= 4'h0;
            busy_reg <= 1'b0;
            sh_reg <= 8'h00;
            done <= 1'b0;
            rx_byte <= 8'h00;
            sck <= 1'b0;
            mosi <= 1'b0;
        end else begin
            done <= 1'b0;
            div_reg <= tick || !busy_reg ? 6'h0 : div_reg + 6'h1;
            if (start && !busy_reg) begin
                busy_reg <= 1'b1;
                sh_reg <= tx_byte;
                mosi <= tx_byte[7];
                edge_reg <= 4'h0;
            end else if (tick) begin
                sck <= ~sck;
                edge_reg <= edge_reg + 4'h1;
                if (!sck) begin
                    rx_byte <= {rx_byte[6:0], miso_sync};
                end else begin
                    sh_reg <= {sh_reg[6:0], 1'b0};
                    mosi <= sh_reg[6];
                end
                if (edge_reg == 4'hF) begin
                    busy_reg <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> hw/sea_host.sv
// Purpose: host end; axi4-lite commands drive the eeprom programming link
// Assumes: software sequences jobs and checks status itself
// Notes: ctrl job codes: 1 unlock, 2 page, 3 lock, 4 status read, 5 finish
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`include "sea_defines.svh"
`default_nettype none
module sea_host (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // link
    sea_link_if.host link
);
    // ***********************
    // registers and bus slave
    // ***********************
    logic [15:0] addr_reg;
    logic [7:0] page_mem [0:63];
    logic [6:0] len_reg;
    logic [7:0] status_seen_reg;
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_reg;
    logic [31:0] w_reg;
    logic start_pulse;
    sea_pkg::sea_job_t job_reg, job_req;
    wire busy = job_reg != sea_pkg::SEA_JOB_IDLE;
    wire do_write = aw_got_reg && w_got_reg && !s_bvalid;
    wire hit_ctrl = aw_reg == `SEA_A_CTRL;
    wire hit_addr = aw_reg == `SEA_A_ADDR;
    wire hit_data = aw_reg == `SEA_A_DATA;
    wire known_w = hit_ctrl || hit_addr || hit_data;
    wire known_r = s_araddr == `SEA_A_CTRL || s_araddr == `SEA_A_ADDR || s_araddr == `SEA_A_STAT;
    wire [31:0] rd_mux = s_araddr == `SEA_A_ADDR ? {16'h0000, addr_reg} :
                         s_araddr == `SEA_A_STAT ? {16'h0000, busy, len_reg, status_seen_reg} :
                         {29'h0000_000, job_reg};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rresp <= 2'b00;
            s_rdata <= 32'h0000_0000;
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_reg <= 8'h00;
            w_reg <= 32'h0000_0000;
            addr_reg <= 16'h0000;
            len_reg <= 7'h00;
            job_req <= sea_pkg::SEA_JOB_IDLE;
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= 1'b0;
            if (s_awvalid && s_awready) begin
                aw_reg <= s_awaddr;
                aw_got_reg <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_reg <= s_wdata;
                w_got_reg <= 1'b1;
                s_wready <= 1'b0;
            end
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp <= known_w ? 2'b00 : 2'b10;
                if (hit_addr && s_wstrb[0]) begin
                    addr_reg <= w_reg[15:0];
                    len_reg <= 7'h00;
                end
                // data writes while a job runs are dropped; the page buffer is shared
                if (hit_data && s_wstrb[0] && !busy && len_reg < 7'(`SEA_PAGE_MAX)) begin
                    page_mem[len_reg[5:0]] <= w_reg[7:0];
                    len_reg <= len_reg + 7'h1;
                end
                if (hit_ctrl && s_wstrb[0] && !busy && w_reg[2:0] >= 3'h1 && w_reg[2:0] <= 3'h5) begin
                    job_req <= sea_pkg::sea_job_t'(w_reg[2:0]);
                    start_pulse <= 1'b1;
                end
            end
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rdata <= rd_mux;
                s_rresp <= known_r ? 2'b00 : 2'b10;
            end
            if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end
    // ***********************
    // link sequencer
    // ***********************
    typedef enum logic [3:0] {
        ST_IDLE, ST_EN, ST_CS, ST_BYTE, ST_WAIT, ST_GAP, ST_RST
    } sea_hst_t;
    sea_hst_t st_reg;
    logic [7:0] seq_mem [0:3];
    logic [1:0] seq_cnt_reg, seq_len_reg;
    logic [6:0] dat_idx_reg;
    logic [1:0] frame_reg;
    logic [4:0] wait_reg;
    logic miso_m, miso_s;
    logic sh_start, sh_done, sh_sck, sh_mosi;
    logic [7:0] sh_tx, sh_rx;
    wire in_data = dat_idx_reg != 7'h00 || (job_reg == sea_pkg::SEA_JOB_PAGE && frame_reg == 2'd1
                   && seq_cnt_reg == 2'd3);
    wire last_byte = job_reg == sea_pkg::SEA_JOB_PAGE && frame_reg == 2'd1
                     ? (dat_idx_reg == len_reg) : (seq_cnt_reg == seq_len_reg);
    wire two_frames = job_reg == sea_pkg::SEA_JOB_UNLOCK || job_reg == sea_pkg::SEA_JOB_LOCK
                      || job_reg == sea_pkg::SEA_JOB_PAGE;
    assign sh_tx = dat_idx_reg != 7'h00 ? page_mem[6'(dat_idx_reg - 7'h1)] : seq_mem[seq_cnt_reg];
    sea_shifter u_shift (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(sh_start),
        .tx_byte(sh_tx),
        .done(sh_done),
        .rx_byte(sh_rx),
        .sck(sh_sck),
        .mosi(sh_mosi),
        .miso_sync(miso_s)
    );
    assign link.sck = sh_sck;
    assign link.serial_in_pin = sh_mosi;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= ST_IDLE;
            job_reg <= sea_pkg::SEA_JOB_IDLE;
            link.direct_access_enable <= 1'b0;
            link.chip_select_n <= 1'b1;
            link.device_reset_n <= 1'b1;
            miso_m <= 1'b0;
            miso_s <= 1'b0;
            sh_start <= 1'b0;
            seq_cnt_reg <= 2'd0;
            seq_len_reg <= 2'd0;
            dat_idx_reg <= 7'h00;
            frame_reg <= 2'd0;
            wait_reg <= 5'h00;
            status_seen_reg <= `SEA_STATUS_RST;
        end else begin
            miso_m <= link.serial_out_pin;
            miso_s <= miso_m;
            sh_start <= 1'b0;
            case (st_reg)
                ST_IDLE: begin
                    if (start_pulse) begin
                        job_reg <= job_req;
                        frame_reg <= 2'd0;
                        st_reg <= job_req == sea_pkg::SEA_JOB_FINISH ? ST_RST : ST_EN;
                        if (job_req == sea_pkg::SEA_JOB_FINISH) begin
                            link.direct_access_enable <= 1'b0;
                            link.device_reset_n <= 1'b0;
                            wait_reg <= 5'(`SEA_RESET_PULSE_CYC);
                        end
                    end
                end
                ST_EN: begin
                    link.direct_access_enable <= 1'b1;
                    seq_cnt_reg <= 2'd0;
                    dat_idx_reg <= 7'h00;
                    // every write job first sets the latch in its own frame
                    if (frame_reg == 2'd0 && two_frames) begin
                        seq_mem[0] <= `SEA_OP_WRITE_LATCH_SET_CMD;
                        seq_len_reg <= 2'd0;
                    end else if (job_reg == sea_pkg::SEA_JOB_PAGE) begin
                        seq_mem[0] <= `SEA_OP_WRITE;
                        seq_mem[1] <= addr_reg[15:8];
                        seq_mem[2] <= addr_reg[7:0];
                        seq_mem[3] <= 8'h00;
                        seq_len_reg <= 2'd3;
                    end else if (job_reg == sea_pkg::SEA_JOB_STATUS) begin
                        seq_mem[0] <= `SEA_OP_RDSR;
                        seq_mem[1] <= 8'h00;
                        seq_len_reg <= 2'd1;
                    end else begin
                        seq_mem[0] <= `SEA_OP_WRSR;
                        seq_mem[1] <= job_reg == sea_pkg::SEA_JOB_LOCK ? `SEA_ST_LOCK : `SEA_ST_UNLOCK;
                        seq_len_reg <= 2'd1;
                    end
                    st_reg <= ST_CS;
                end
                ST_CS: begin
                    link.chip_select_n <= 1'b0;
                    sh_start <= 1'b1;
                    st_reg <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (sh_done) begin
                        if (job_reg == sea_pkg::SEA_JOB_STATUS && seq_cnt_reg == 2'd1) begin
                            status_seen_reg <= sh_rx;
                        end
                        // page with no data ends after the opcode byte
                        if (last_byte && !(in_data == 1'b0 && job_reg == sea_pkg::SEA_JOB_PAGE
                            && frame_reg == 2'd1 && seq_cnt_reg == 2'd2 && len_reg != 7'h00)) begin
                            link.chip_select_n <= 1'b1;
                            st_reg <= ST_GAP;
                        end else begin
                            if (seq_cnt_reg == 2'd2 && job_reg == sea_pkg::SEA_JOB_PAGE) begin
                                seq_cnt_reg <= 2'd3;
                                dat_idx_reg <= 7'h01;
                            end else if (dat_idx_reg != 7'h00) begin
                                dat_idx_reg <= dat_idx_reg + 7'h1;
                            end else begin
                                seq_cnt_reg <= seq_cnt_reg + 2'd1;
                            end
                            st_reg <= ST_BYTE;
                        end
                    end
                end
                ST_BYTE: begin
                    sh_start <= 1'b1;
                    st_reg <= ST_WAIT;
                end
                ST_GAP: begin
                    if (two_frames && frame_reg == 2'd0) begin
                        frame_reg <= 2'd1;
                        st_reg <= ST_EN;
                    end else begin
                        job_reg <= sea_pkg::SEA_JOB_IDLE;
                        st_reg <= ST_IDLE;
                    end
                end
                ST_RST: begin
                    wait_reg <= wait_reg - 5'h01;
                    if (wait_reg == 5'h01) begin
                        link.device_reset_n <= 1'b1;
                        job_reg <= sea_pkg::SEA_JOB_IDLE;
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> hw/sea_device.sv
// Purpose: device end; embedded eeprom reached while direct access is on
// Assumes: link pins come from another clock domain
// Notes: user side shows status word and an image read port
`include "sea_defines.svh"
`default_nettype none
module sea_device (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    sea_link_if.device link,
    // user side
    input wire logic [15:0] peek_addr,
    output logic [7:0] peek_data,
    output logic [7:0] status_word,
    output logic restart_pulse
);
    logic [7:0] mem [0:`SEA_MEM_WORDS-1];
    logic [1:0] en_s, cs_s, sck_s, di_s, rst_s;
    logic sck_d, rst_d;
    logic [7:0] sh_reg, op_reg, st_reg;
    logic [2:0] bit_reg;
    logic [15:0] cnt_reg, wa_reg;
    logic [10:0] busy_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_s <= 2'b00; cs_s <= 2'b11; sck_s <= 2'b00; di_s <= 2'b00; rst_s <= 2'b11;
        end else begin
            en_s <= {en_s[0], link.direct_access_enable};
            cs_s <= {cs_s[0], link.chip_select_n};
            sck_s <= {sck_s[0], link.sck};
            di_s <= {di_s[0], link.serial_in_pin};
            rst_s <= {rst_s[0], link.device_reset_n};
        end
    end
    wire sel = en_s[1] && !cs_s[1];
    wire rise = sel && sck_s[1] && !sck_d;
    wire fall = sel && !sck_s[1] && sck_d;
    wire [7:0] byte_in = {sh_reg[6:0], di_s[1]};
    wire byte_end = rise && bit_reg == 3'd7;
    wire busy = busy_reg != 11'h000;
    wire prot = st_reg[`SEA_BIT_PROT_HI] || st_reg[`SEA_BIT_PROT_LO];
    wire wr_ok = st_reg[`SEA_BIT_LATCH] && !busy;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_d <= 1'b0; rst_d <= 1'b1;
            sh_reg <= 8'h00; op_reg <= 8'h00; bit_reg <= 3'd0; cnt_reg <= 16'h0000; wa_reg <= 16'h0000;
            st_reg <= `SEA_ST_LOCK;
            busy_reg <= 11'h000;
            link.serial_out_pin <= 1'b0;
            peek_data <= 8'h00; status_word <= `SEA_ST_LOCK; restart_pulse <= 1'b0;
        end else begin
            sck_d <= sck_s[1];
            rst_d <= rst_s[1];
            restart_pulse <= rst_d && !rst_s[1];
            peek_data <= mem[peek_addr];
            status_word <= {st_reg[7:2], st_reg[1], busy};
            if (busy) busy_reg <= busy_reg - 11'h001;
            if (!sel) begin
                bit_reg <= 3'd0; cnt_reg <= 16'h0000;
                // write starts when the frame closes, only after a full byte
                if (cnt_reg != 16'h0000 && wr_ok) begin
                    if (op_reg == `SEA_OP_WRITE && cnt_reg > 16'h0003) begin
                        busy_reg <= 11'(`SEA_WRITE_BUSY_CYC); st_reg[`SEA_BIT_LATCH] <= 1'b0;
                    end else if (op_reg == `SEA_OP_WRSR && cnt_reg > 16'h0001) begin
                        busy_reg <= 11'(`SEA_WRITE_BUSY_CYC); st_reg[`SEA_BIT_LATCH] <= 1'b0;
                    end
                end
            end else begin
                if (rise) begin
                    sh_reg <= byte_in; bit_reg <= bit_reg + 3'd1;
                end
                if (fall) begin
                    // only the rise shifts; a second shift here would drop every other bit
                    link.serial_out_pin <= sh_reg[7];
                end
                if (byte_end) begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == 16'h0000) begin
                        op_reg <= byte_in;
                        if (byte_in == `SEA_OP_WRITE_LATCH_SET_CMD && !busy) st_reg[`SEA_BIT_LATCH] <= 1'b1;
                        if (byte_in == `SEA_OP_RDSR) sh_reg <= {st_reg[7:1], busy};
                        if (byte_in == `SEA_OP_READ) sh_reg <= 8'h00;
                    end else if (op_reg == `SEA_OP_WRSR && cnt_reg == 16'h0001 && wr_ok) begin
                        st_reg[7] <= byte_in[7];
                        st_reg[3:2] <= byte_in[3:2];
                    end else if (op_reg == `SEA_OP_WRITE || op_reg == `SEA_OP_READ) begin
                        if (cnt_reg == 16'h0001) wa_reg[15:8] <= byte_in;
                        else if (cnt_reg == 16'h0002) wa_reg[7:0] <= byte_in;
                        else begin
                            // same path for all zones; address wraps inside the 128-byte aligned region
                            if (op_reg == `SEA_OP_WRITE && wr_ok && !prot) begin
                                mem[wa_reg] <= byte_in;
                            end
                            if (op_reg == `SEA_OP_READ) sh_reg <= mem[wa_reg];
                            wa_reg <= {wa_reg[15:7], 7'(wa_reg[6:0] + 7'h01)};
                        end
                        if (op_reg == `SEA_OP_READ && cnt_reg == 16'h0002) sh_reg <= mem[{wa_reg[15:8], byte_in}];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> verification/sea_link_properties.sv
// Purpose: concurrent checks on the link between host and device
// Assumes: one aclk domain, link pins sampled on aclk
// Notes: half period of sck is 7 aclk cycles
`default_nettype none
module sea_link_properties (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic direct_access_enable,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic device_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_sck_high_time: assert property ($rose(sck) |-> sck [*7])
        else $error("sck high phase too short");
    chk_sck_low_time: assert property ($fell(sck) |-> !sck [*7])
        else $error("sck low phase too short");
    chk_frame_enable: assert property (!chip_select_n |-> direct_access_enable)
        else $error("frame without direct access enable");
    chk_sck_idle: assert property (chip_select_n |-> !sck)
        else $error("sck moves while deselected");
    chk_din_hold: assert property (sck && $past(sck) |-> $stable(serial_in_pin))
        else $error("serial input changed while sck high");
    chk_select_edge: assert property ($changed(chip_select_n) |-> !sck && $past(!sck))
        else $error("select moved near an sck edge");
    chk_reset_pulse: assert property ($fell(device_reset_n) |-> !device_reset_n [*8] ##[1:40] device_reset_n)
        else $error("device reset pulse length wrong");
    chk_release_first: assert property ($fell(device_reset_n) |-> !direct_access_enable && chip_select_n)
        else $error("device reset while direct access on");
    cover property ($rose(chip_select_n));
    cover property (!chip_select_n && serial_out_pin);
    cover property ($fell(device_reset_n));
endmodule
`default_nettype wire

// >>> verification/spi_eeprom_page_write_access_test.sv
// Purpose: self-checking run of host and device joined by the link
// Assumes: host idles with stat bit 15 low
// Notes: reads queue their expectation, a monitor compares
`include "sea_defines.svh"
`default_nettype none
module spi_eeprom_page_write_access_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic restart_pulse;
    logic [7:0] awaddr, araddr, peek_data, status_word;
    logic [7:0] img [0:63];
    logic [31:0] wdata, rd, rdata;
    logic [15:0] peek_addr, base;
    logic [1:0] bresp, rresp;
    logic [65:0] note_q [$];
    int bad_count, comparisons, restarts;
    sea_link_if link();
    sea_host u_sea_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .link(link));
    sea_device u_sea_device (.aclk(aclk), .aresetn(aresetn), .link(link), .peek_addr(peek_addr),
        .peek_data(peek_data), .status_word(status_word), .restart_pulse(restart_pulse));
    sea_link_properties u_sea_link_properties (.aclk(aclk), .aresetn(aresetn),
        .direct_access_enable(link.direct_access_enable), .chip_select_n(link.chip_select_n), .sck(link.sck),
        .serial_in_pin(link.serial_in_pin), .serial_out_pin(link.serial_out_pin),
        .device_reset_n(link.device_reset_n));
    // ****************************************
    // checking
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic hang();
        bad_count++;
        test_done();
    endtask
    always @(posedge aclk) begin
        if (restart_pulse) restarts++;
        if (rvalid && rready && note_q.size() > 0) begin
            check("rdata", rdata & note_q[0][63:32], note_q[0][31:0] & note_q[0][63:32]);
            check("rresp", {30'h0, rresp}, {30'h0, note_q[0][65:64]});
            void'(note_q.pop_front());
        end
    end
    // ****************************************
    // drivers
    // ****************************************
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 1000; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        check("bresp", {30'h0, bresp}, 32'h0);
        if (i == 1000) hang();
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        int i;
        note_q.push_back({r, m, e});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 1000; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rready <= 1'b0;
        if (i == 1000) hang();
        @(posedge aclk);
    endtask
    task automatic job(input logic [2:0] j);
        int i;
        axi_wr(`SEA_A_CTRL, {29'h0, j});
        for (i = 0; i < 5000; i++) begin
            axi_rd(`SEA_A_STAT, 32'h0, 32'h0, 2'h0);
            if (!rd[15]) break;
        end
        if (i == 5000) hang();
    endtask
    task automatic status(input logic [7:0] m, input logic [7:0] e);
        job(3'h4);
        axi_rd(`SEA_A_STAT, {24'h0, m}, {24'h0, e}, 2'h0);
    endtask
    task automatic page(input logic [15:0] a, input int cnt);
        int i;
        axi_wr(`SEA_A_ADDR, {16'h0, a});
        for (i = 0; i < cnt; i++) axi_wr(`SEA_A_DATA, {24'h0, img[i]});
        job(3'h2);
    endtask
    task automatic wait_write();
        int i;
        status(8'h01, 8'h01);
        for (i = 0; i < 50 && rd[0]; i++) status(8'h00, 8'h00);
        if (rd[0]) hang();
    endtask
    task automatic peek(input logic [15:0] a, input int cnt);
        int i;
        for (i = 0; i < cnt; i++) begin
            peek_addr <= a + 16'(i);
            repeat (2) @(posedge aclk);
            check("peek_data", {24'h0, peek_data}, {24'h0, img[i]});
        end
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, peek_addr} = '0;
        void'($urandom(44));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(8'h10, 32'h0, 32'h0, 2'h2);
        status(8'h0c, 8'h0c);
        job(3'h1);
        wait_write();
        status(8'h0c, 8'h00);
        base = 16'($urandom) & 16'hff80;
        foreach (img[k]) img[k] = 8'($urandom);
        page(base, 64);
        wait_write();
        peek(base, 64);
        page(16'hfdc0, 5);
        wait_write();
        peek(16'hfdc0, 5);
        job(3'h3);
        wait_write();
        status(8'h0c, 8'h0c);
        check("status_word", {24'h0, status_word}, 32'h0000_000c);
        img[0] = ~img[0];
        page(base, 1); // locked, so refused
        img[0] = ~img[0];
        repeat (3000) @(posedge aclk);
        peek(base, 1);
        job(3'h5);
        repeat (`SEA_RESET_PULSE_CYC + 8) @(posedge aclk);
        check("restarts", 32'(restarts), 32'h0000_0001);
        check("enable", {31'h0, link.direct_access_enable}, 32'h0000_0000);
        test_done();
    end
endmodule
`default_nettype wire
